// [src/eeprom_host.sv]
// Host controller driving a paged 64K x 16 EEPROM through its parallel pins.
`timescale 1ns/10ps
module eeprom_host
	import eeprom_host_pkg::*;
#(
	parameter int POWER_ON_CYCLES = POWER_ON_CYC,
	parameter int TIMEOUT_CYCLES = WRITE_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// User command port
	input wire logic cmdValid,
	input wire host_cmd_t cmd,
	input wire logic cmdLast,
	output logic cmdReady,
	output logic rdValid,
	output logic [15:0] rdData,
	output logic wrDone,
	output logic wrTimeout,
	// Device pins
	output mem_ctrl_t memCtrl,
	input wire logic [15:0] dataIn,
	output logic [15:0] dataOut,
	output logic dataOeN
);
	typedef enum logic [3:0] {
		ST_POWERUP, ST_IDLE, ST_RD_WAIT, ST_WR_LOW, ST_WR_HIGH, ST_LOADED,
		ST_UNLK, ST_POLL_LOW, ST_POLL_HIGH
	} state_t;

	state_t state_r, state_nxt;
	logic [23:0] count_r;
	logic [23:0] busy_r;
	logic [1:0] unlockIdx_r;
	logic pendLast_r;
	logic prevToggle_r;
	logic firstPoll_r;
	logic finished_r;
	logic [15:0] dinSync1_r, dinSync2_r;
	logic [15:0] pageAddr_r;
	logic [15:0] pageData_r;
	logic pageId_r;
	mem_ctrl_t ctrl_r;
	logic [15:0] dout_r;
	logic oeN_r;
	logic ready_r, rdValid_r, wrDone_r, wrTo_r;
	logic [15:0] rdData_r;

	// Unlock word for step i
	function automatic logic [31:0] unlockWord(input logic [1:0] i);
		unique case (i)
			2'd0: unlockWord = {UNLOCK_ADDR0, UNLOCK_DATA0};
			2'd1: unlockWord = {UNLOCK_ADDR1, UNLOCK_DATA1};
			default: unlockWord = {UNLOCK_ADDR0, UNLOCK_DATA2};
		endcase
	endfunction

	wire [31:0] unlockSel = unlockWord(unlockIdx_r);
	wire countDone = (count_r == 24'd0);
	// Toggle settled and the poll bits equal what was written
	wire toggleStill = !firstPoll_r && (dinSync2_r[TOGGLE_BIT] == prevToggle_r);
	wire pollTrue = (dinSync2_r[POLL_BIT_LO] == dout_r[POLL_BIT_LO]) &&
		(dinSync2_r[POLL_BIT_HI] == dout_r[POLL_BIT_HI]);
	// Trusted only after a full load window, so the old stored word cannot pass as done
	wire windowClosed = (busy_r >= 24'(LOAD_WINDOW_CYC + READ_WAIT_CYC));
	// Judged on the word read while output enable was low
	wire writeFinished = toggleStill && pollTrue && windowClosed;
	wire timedOut = (busy_r >= 24'(TIMEOUT_CYCLES));

	// Input pins come from outside the clock domain
	always_ff @(posedge clock) begin
		dinSync1_r <= dataIn;
		dinSync2_r <= dinSync1_r;
	end

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_POWERUP: if (countDone) state_nxt = ST_IDLE;
			ST_IDLE: begin
				if (cmdValid && cmd.write && cmd.unlock)
					state_nxt = ST_UNLK;
				else if (cmdValid && cmd.write)
					state_nxt = ST_WR_LOW;
				else if (cmdValid)
					state_nxt = ST_RD_WAIT;
			end
			ST_UNLK: state_nxt = ST_WR_LOW;
			ST_RD_WAIT: if (countDone) state_nxt = ST_IDLE;
			ST_WR_LOW: if (countDone) state_nxt = ST_WR_HIGH;
			ST_WR_HIGH: begin
				if (countDone && unlockIdx_r != 2'd0 && unlockIdx_r != 2'd3)
					state_nxt = ST_UNLK;
				else if (countDone && unlockIdx_r == 2'd3)
					state_nxt = ST_WR_LOW;
				else if (countDone && pendLast_r)
					state_nxt = ST_POLL_LOW;
				else if (countDone)
					state_nxt = ST_LOADED;
			end
			ST_LOADED: begin
				if (cmdValid && cmd.write)
					state_nxt = ST_WR_LOW;
				else if (countDone)
					state_nxt = ST_POLL_LOW;
			end
			ST_POLL_LOW: if (countDone) state_nxt = ST_POLL_HIGH;
			ST_POLL_HIGH: begin
				if (countDone && (finished_r || timedOut))
					state_nxt = ST_IDLE;
				else if (countDone)
					state_nxt = ST_POLL_LOW;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Sequencer with timing counter and pin registers
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_POWERUP;
			count_r <= 24'(POWER_ON_CYCLES);
			busy_r <= 24'd0;
			unlockIdx_r <= 2'd0;
			pendLast_r <= 1'b0;
			prevToggle_r <= 1'b0;
			firstPoll_r <= 1'b1;
			finished_r <= 1'b0;
			pageAddr_r <= 16'h0000;
			pageData_r <= 16'h0000;
			pageId_r <= 1'b0;
			ctrl_r <= '{1'b1, 1'b1, 1'b1, 1'b0, 16'h0000};
			dout_r <= 16'h0000;
			oeN_r <= 1'b1;
			ready_r <= 1'b0;
			rdValid_r <= 1'b0;
			wrDone_r <= 1'b0;
			wrTo_r <= 1'b0;
			rdData_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			rdValid_r <= 1'b0;
			wrDone_r <= 1'b0;
			wrTo_r <= 1'b0;
			count_r <= countDone ? 24'd0 : count_r - 24'd1;
			busy_r <= (state_r == ST_POLL_LOW || state_r == ST_POLL_HIGH) ? busy_r + 24'd1 : busy_r;
			ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_LOADED);
			unique case (state_nxt)
				ST_IDLE: begin
					// Bus released, chip, output and write enables deselected; the bit 9 select keeps its value
					ctrl_r.chipEnableN <= 1'b1;
					ctrl_r.outputEnableN <= 1'b1;
					ctrl_r.writeEnableN <= 1'b1;
					oeN_r <= 1'b1;
				end
				ST_RD_WAIT: if (state_r == ST_IDLE) begin
					ctrl_r <= '{1'b0, 1'b0, 1'b1, cmd.idArea, cmd.addr};
					oeN_r <= 1'b1;
					count_r <= 24'(READ_WAIT_CYC);
				end
				ST_UNLK: begin
					count_r <= 24'd0;
					unlockIdx_r <= (state_r == ST_IDLE) ? 2'd0 : unlockIdx_r;
					pendLast_r <= (state_r == ST_IDLE) ? cmdLast : pendLast_r;
					pageAddr_r <= (state_r == ST_IDLE) ? cmd.addr : pageAddr_r;
					// The page word waits here while the prefix goes out
					pageData_r <= (state_r == ST_IDLE) ? cmd.data : pageData_r;
					pageId_r <= (state_r == ST_IDLE) ? cmd.idArea : pageId_r;
				end
				ST_WR_LOW: if (state_r != ST_WR_LOW) begin
					// OE high before the strobe falls keeps the write legal
					ctrl_r.outputEnableN <= 1'b1;
					ctrl_r.chipEnableN <= 1'b0;
					ctrl_r.writeEnableN <= 1'b0;
					oeN_r <= 1'b0;
					count_r <= 24'(STROBE_LOW_CYC);
					if (state_r == ST_UNLK) begin
						ctrl_r.addr <= unlockSel[31:16];
						dout_r <= unlockSel[15:0];
						ctrl_r.addressBit9HvSelect <= 1'b0;
						unlockIdx_r <= unlockIdx_r + 2'd1;
					end else if (state_r == ST_WR_HIGH) begin
						// Prefix done, now the held page word
						ctrl_r.addr <= pageAddr_r;
						dout_r <= pageData_r;
						ctrl_r.addressBit9HvSelect <= pageId_r;
						unlockIdx_r <= 2'd0;
					end else begin
						// Page bits kept from the first word of the load
						ctrl_r.addr <= {(state_r == ST_LOADED) ? ctrl_r.addr[15:6] : cmd.addr[15:6],
							cmd.addr[5:0]};
						dout_r <= cmd.data;
						ctrl_r.addressBit9HvSelect <= cmd.idArea;
						pendLast_r <= cmdLast;
						unlockIdx_r <= 2'd0;
					end
				end
				ST_WR_HIGH: if (state_r == ST_WR_LOW) begin
					ctrl_r.writeEnableN <= 1'b1;
					count_r <= 24'(STROBE_HIGH_CYC);
				end
				ST_LOADED: if (state_r == ST_WR_HIGH) begin
					oeN_r <= 1'b1;
					count_r <= 24'(LOAD_WINDOW_CYC / 2);
				end
				ST_POLL_LOW: if (state_r != ST_POLL_LOW) begin
					// Poll the last written word by toggling OE
					ctrl_r.writeEnableN <= 1'b1;
					ctrl_r.chipEnableN <= 1'b0;
					ctrl_r.outputEnableN <= 1'b0;
					oeN_r <= 1'b1;
					count_r <= 24'(READ_WAIT_CYC);
					if (state_r != ST_POLL_HIGH) begin
						busy_r <= 24'd0;
						firstPoll_r <= 1'b1;
						finished_r <= 1'b0;
					end
				end
				ST_POLL_HIGH: if (state_r == ST_POLL_LOW) begin
					ctrl_r.outputEnableN <= 1'b1;
					prevToggle_r <= dinSync2_r[TOGGLE_BIT];
					// Bus floats once output enable rises, so judge now
					finished_r <= writeFinished;
					firstPoll_r <= 1'b0;
					count_r <= 24'(STROBE_LOW_CYC);
				end
				default: ;
			endcase
			// Read result captured as the read phase ends
			if (state_r == ST_RD_WAIT && countDone) begin
				rdValid_r <= 1'b1;
				rdData_r <= dinSync2_r;
			end
			// Completion or timeout of a programming period
			if (state_r == ST_POLL_HIGH && countDone && (finished_r || timedOut)) begin
				wrDone_r <= finished_r;
				wrTo_r <= !finished_r;
			end
		end
	end

	assign cmdReady = ready_r;
	assign rdValid = rdValid_r;
	assign rdData = rdData_r;
	assign wrDone = wrDone_r;
	assign wrTimeout = wrTo_r;
	assign memCtrl = ctrl_r;
	assign dataOut = dout_r;
	assign dataOeN = oeN_r;
endmodule

// [src/eeprom_host_pkg.sv]
// Package for the paged word EEPROM host controller: constants, types, notes.
// Notes on behaviour
// - Write starts by strobe pulse, OE high
// - Next fall within 150 us of rise
// - Hold page bits 15:6 constant per load
// - Protection enabled by three command writes
// - Unlock: AAAA@5555, 5555@AAAA, A0A0@5555
// - When protected, unlock precedes every page
// - Command writes obey page-load timing
// - Address bit 9 high voltage reaches id words
package eeprom_host_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int PAGE_WORDS = 64;
	localparam int LOAD_WINDOW_US = 150;
	localparam int POWER_ON_MS = 5;
	localparam int WRITE_TIMEOUT_MS = 10;
	// Window is a longest time, so round down
	localparam int LOAD_WINDOW_CYC = CLK_HZ / 1000000 * LOAD_WINDOW_US;
	// Power-on delay and timeout are least times; CLK_HZ / 1000 rounds down, exact at 25 MHz
	localparam int POWER_ON_CYC = (CLK_HZ / 1000) * POWER_ON_MS;
	localparam int WRITE_TIMEOUT_CYC = (CLK_HZ / 1000) * WRITE_TIMEOUT_MS;
	localparam int STROBE_LOW_CYC = 4; // 160 ns covers the write pulse width
	localparam int STROBE_HIGH_CYC = 2; // 80 ns covers pulse high time
	localparam int READ_WAIT_CYC = 7; // 280 ns covers slowest access
	localparam logic [15:0] UNLOCK_ADDR0 = 16'h5555;
	localparam logic [15:0] UNLOCK_DATA0 = 16'haaaa;
	localparam logic [15:0] UNLOCK_ADDR1 = 16'haaaa;
	localparam logic [15:0] UNLOCK_DATA1 = 16'h5555;
	localparam logic [15:0] UNLOCK_DATA2 = 16'ha0a0;
	localparam int POLL_BIT_LO = 7;
	localparam int POLL_BIT_HI = 15;
	localparam int TOGGLE_BIT = 14;
	localparam logic [15:0] ID_BASE = 16'hffc0;

	// Pins toward the device
	typedef struct packed {
		logic chipEnableN;
		logic outputEnableN;
		logic writeEnableN;
		logic addressBit9HvSelect;
		logic [15:0] addr;
	} mem_ctrl_t;

	// User command
	typedef struct packed {
		logic write;
		logic unlock;
		logic idArea;
		logic [15:0] addr;
		logic [15:0] data;
	} host_cmd_t;
endpackage

// [tb/eeprom_host_bench.sv]
// Self-checking bench for the paged EEPROM host controller.
`timescale 1ns/10ps
module eeprom_host_bench
	import eeprom_host_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cmdValid = 1'b0;
	host_cmd_t cmd = '0;
	logic cmdLast = 1'b0;
	logic cmdReady, rdValid, wrDone, wrTimeout, dataOeN, drive;
	logic [15:0] rdData, dataIn, dataOut, q;
	mem_ctrl_t memCtrl;
	int n_fail = 0;
	int num_checks = 0;
	always #20 clock = ~clock;
	// Released lines show a moving pattern, never the last value
	assign dataIn = !dataOeN ? dataOut : drive ? q : 16'h5a5a ^ {16{clock}};
	eeprom_host #(.POWER_ON_CYCLES(20), .TIMEOUT_CYCLES(20000)) uut (.clock(clock), .rst(rst),
		.cmdValid(cmdValid), .cmd(cmd), .cmdLast(cmdLast), .cmdReady(cmdReady),
		.rdValid(rdValid), .rdData(rdData), .wrDone(wrDone), .wrTimeout(wrTimeout),
		.memCtrl(memCtrl), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN));
	eeprom_model dev (.clock(clock), .pins(memCtrl), .bus(dataIn), .drive(drive), .q(q));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Ready is read at the falling edge, so the take is the next rising edge
	task automatic issue(input logic w, u, i, l, input logic [15:0] a, d);
		@(posedge clock);
		cmdValid <= 1'b1;
		cmd <= '{w, u, i, a, d};
		cmdLast <= l;
		@(negedge clock);
		while (cmdReady !== 1'b1)
			@(negedge clock);
		@(posedge clock);
		cmdValid <= 1'b0;
	endtask
	task automatic rd(input logic i, input logic [15:0] a, e);
		issue(1'b0, 1'b0, i, 1'b0, a, 16'h0);
		while (rdValid !== 1'b1)
			@(negedge clock);
		chk(rdData, e);
	endtask
	task automatic wr_end;
		while (wrDone !== 1'b1 && wrTimeout !== 1'b1)
			@(negedge clock);
		chk({15'h0, wrDone}, 16'h1);
	endtask
	task automatic t_page;
		issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0105, 16'h1234);
		issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0102, 16'habcd);
		issue(1'b1, 1'b0, 1'b0, 1'b1, 16'h0105, 16'h8181);
		wr_end;
		rd(1'b0, 16'h0105, 16'h8181);
		rd(1'b0, 16'h0102, 16'habcd);
		rd(1'b0, 16'h0103, 16'hffff);
		$display("t_page done");
	endtask
	task automatic t_id;
		issue(1'b1, 1'b0, 1'b1, 1'b1, 16'hffc0, 16'h5a5a);
		wr_end;
		rd(1'b0, 16'hffc0, 16'hffff);
		rd(1'b1, 16'hffc0, 16'h5a5a);
		$display("t_id done");
	endtask
	// A plain write after protection is dropped; only unlocked pages land
	task automatic t_prot;
		issue(1'b1, 1'b1, 1'b0, 1'b1, 16'h0200, 16'h1111);
		wr_end;
		issue(1'b1, 1'b0, 1'b0, 1'b1, 16'h0200, 16'h2222);
		rd(1'b0, 16'h0200, 16'h1111);
		issue(1'b1, 1'b1, 1'b0, 1'b1, 16'h0200, 16'h3333);
		wr_end;
		rd(1'b0, 16'h0200, 16'h3333);
		$display("t_prot done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_page;
		t_id;
		t_prot;
		print_verdict;
	end
	// Five programming periods of about 6000 cycles each, with wide margin
	initial begin
		#(40 * 60000);
		n_fail++;
		print_verdict;
	end
endmodule

// [tb/eeprom_host_monitor.sv]
// Checker of the host controller's pin and command behaviour.
`timescale 1ns/10ps
module eeprom_host_monitor
	import eeprom_host_pkg::*;
#(
	parameter int POWER_ON_CYCLES = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command side
	input wire logic cmdValid,
	input wire host_cmd_t cmd,
	input wire logic cmdLast,
	input wire logic cmdReady,
	input wire logic rdValid,
	input wire logic [15:0] rdData,
	input wire logic wrDone,
	input wire logic wrTimeout,
	// Device side
	input wire mem_ctrl_t memCtrl,
	input wire logic [15:0] dataIn,
	input wire logic [15:0] dataOut,
	input wire logic dataOeN
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire take = cmdValid && cmdReady;
	wire weLow = !memCtrl.writeEnableN;
	logic [31:0] upCnt_r;
	// Saturating count since reset, so a long run cannot wrap
	always_ff @(posedge clock) begin
		if (rst)
			upCnt_r <= 32'h0;
		else if (upCnt_r != 32'hffffffff)
			upCnt_r <= upCnt_r + 32'h1;
	end
	a_power_delay: assert property (cmdReady |-> upCnt_r >= POWER_ON_CYCLES - 1)
		else $error("ready before power-on delay");
	a_write_oe_high: assert property (weLow |-> memCtrl.outputEnableN && !memCtrl.chipEnableN)
		else $error("write strobe without select or with output enable");
	a_no_contend: assert property (!memCtrl.chipEnableN && !memCtrl.outputEnableN |-> dataOeN)
		else $error("host drives data during a read");
	a_data_held: assert property (weLow && $past(weLow) |-> $stable(dataOut) && $stable(memCtrl.addr))
		else $error("data or address moved under the strobe");
	a_strobe_width: assert property ($fell(memCtrl.writeEnableN) |-> weLow [*4])
		else $error("write strobe too short");
	a_unlock_first: assert property (take && cmd.write && cmd.unlock |-> ##2 weLow
		&& memCtrl.addr == UNLOCK_ADDR0 && dataOut == UNLOCK_DATA0)
		else $error("unlock prefix does not start the page");
	a_read_strobe: assert property (take && !cmd.write |=> !memCtrl.chipEnableN
		&& !memCtrl.outputEnableN && memCtrl.addr == $past(cmd.addr))
		else $error("read not started at the taken address");
	a_id_select: assert property (take && cmd.idArea |=> memCtrl.addressBit9HvSelect)
		else $error("id area select missing");
endmodule

bind eeprom_host eeprom_host_monitor #(.POWER_ON_CYCLES(POWER_ON_CYCLES)) mon (.clock(clock),
	.rst(rst), .cmdValid(cmdValid), .cmd(cmd), .cmdLast(cmdLast), .cmdReady(cmdReady),
	.rdValid(rdValid), .rdData(rdData), .wrDone(wrDone), .wrTimeout(wrTimeout),
	.memCtrl(memCtrl), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN));

// [tb/eeprom_model.sv]
// Behavioural paged word EEPROM answering the host controller.
`timescale 1ns/10ps
module eeprom_model
	import eeprom_host_pkg::*;
#(
	parameter int PROG_CYC = 2000,
	parameter int WIN_CYC = LOAD_WINDOW_CYC,
	parameter int PWR_CYC = 20
) (
	// Pins
	input wire logic clock,
	input wire mem_ctrl_t pins,
	input wire logic [15:0] bus,
	output logic drive,
	output logic [15:0] q
);
	logic [15:0] mem [131072];
	logic [15:0] pl [int];
	logic [15:0] lw;
	logic [16:0] la;
	int busy = 0;
	int win = 0;
	int stage = 0;
	int age = 0;
	logic prot = 1'b0;
	logic tog = 1'b0;
	mem_ctrl_t p;
	wire [16:0] key = {pins.addressBit9HvSelect, pins.addr};
	wire wsel = !pins.chipEnableN && pins.outputEnableN && age >= PWR_CYC;
	wire [15:0] uA = stage == 1 ? UNLOCK_ADDR1 : UNLOCK_ADDR0;
	wire [15:0] uD = stage == 0 ? UNLOCK_DATA0 : stage == 1 ? UNLOCK_DATA1 : UNLOCK_DATA2;
	assign drive = !pins.chipEnableN && !pins.outputEnableN && pins.writeEnableN;
	// Busy reads show complemented polling bits and the toggle
	assign q = busy > 0 ? {~lw[15], tog, lw[13:8], ~lw[7], lw[6:0]} : mem[key];
	initial begin
		foreach (mem[i])
			mem[i] = 16'hffff;
	end
	// Edges are found against last cycle's pins; the load closes a full window after the last rise
	always @(posedge clock) begin
		if (busy > 0) begin
			busy--;
			if (!p.outputEnableN && pins.outputEnableN)
				tog = ~tog;
		end else begin
			if (p.writeEnableN && !pins.writeEnableN && wsel)
				la = key;
			if (!p.writeEnableN && pins.writeEnableN && wsel) begin
				win = 0;
				if (stage < 3 && la[15:0] == uA && bus == uD)
					stage++;
				else begin
					pl[la] = bus;
					lw = bus;
				end
			end
			if (stage > 0 || pl.num() > 0)
				win++;
			if (win == WIN_CYC) begin
				if (!prot || stage == 3)
					foreach (pl[k])
						mem[k] = pl[k];
				prot = prot || stage == 3;
				busy = PROG_CYC;
				pl.delete();
				stage = 0;
				win = 0;
			end
		end
		p = pins;
		if (age < PWR_CYC)
			age++;
	end
endmodule
